// File: uppg_defines.svh
// Register offsets, field positions, reset values for the upper port block
`ifndef UPPG_DEFINES_SVH
`define UPPG_DEFINES_SVH

`define UPPG_PAGE_OFS 12'h000
`define UPPG_CFG_OFS 12'h004
`define UPPG_RMW_OFS 12'h008
`define UPPG_STAT_OFS 12'h00C
`define UPPG_DATA_BASE 12'h010
`define UPPG_MODE_BASE 12'h020
`define UPPG_BANK_MASK 12'hFF0

`define UPPG_PORT_PAGE 8'h0F
`define UPPG_PAGE_RST 8'h00
`define UPPG_DATA_RST 8'hFF
`define UPPG_MODE_RST 8'h00
`define UPPG_PUD_RST 1'b0
`define UPPG_P4_MASK 8'hE0
`define UPPG_FULL_MASK 8'hFF

`define UPPG_CFG_PUD_BIT 0
`define UPPG_RMW_PORT_LSB 0
`define UPPG_RMW_PORT_MSB 1
`define UPPG_RMW_OP_LSB 2
`define UPPG_RMW_OP_MSB 3
`define UPPG_RMW_ARG_LSB 8
`define UPPG_RMW_ARG_MSB 15
`define UPPG_STAT_PAGE_BIT 0
`define UPPG_STAT_LAST_LSB 8
`define UPPG_STAT_LAST_MSB 15

`define UPPG_NUM_PINS 27

`endif

// File: uppg_pkg.sv
// Types shared by the upper port block
package uppg_pkg;

    typedef logic [7:0] uppg_byte_t;
    typedef logic [1:0] uppg_port_idx_t;

    typedef enum logic [1:0] {
        UPPG_OP_AND = 2'b00,
        UPPG_OP_OR = 2'b01,
        UPPG_OP_XOR = 2'b10,
        UPPG_OP_CPL = 2'b11
    } uppg_rmw_op_t;

    typedef enum logic [1:0] {
        UPPG_ST_IDLE = 2'b00,
        UPPG_ST_READ = 2'b01,
        UPPG_ST_WRITE = 2'b10,
        UPPG_ST_DONE = 2'b11
    } uppg_rmw_state_t;

endpackage

// File: uppg_pin_if.sv
// Port data, mode and pull-up control passed from register logic to pad logic
`timescale 1ns/1ps
interface uppg_pin_if;
    logic [31:0] data_bits;
    logic [31:0] mode_bits;
    logic pullup_dis;

    modport ctrl
    (
        output data_bits,
        output mode_bits,
        output pullup_dis
    );

    modport pad
    (
        input data_bits,
        input mode_bits,
        input pullup_dis
    );
endinterface

// File: uppg_sync.sv
// Two-stage synchroniser for the pin levels
`timescale 1ns/1ps
module uppg_sync
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [26:0] async_in,
    output logic [26:0] sync_out
);
    logic [26:0] meta_reg;

    // First stage feeds only the second
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            meta_reg <= 27'h0;
            sync_out <= 27'h0;
        end
        else
        begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule

// File: uppg_pad_drive.sv
// Registered pad drivers: output level, output enable, pull-up enable
`timescale 1ns/1ps
module uppg_pad_drive
(
    input wire logic pclk,
    input wire logic presetn,
    uppg_pin_if.pad pins,
    output logic [26:0] pin_out,
    output logic [26:0] pin_oe,
    output logic pin_pullup_en
);
    logic [31:0] oe_full;

    // Only pins 5..7 of the fourth port reach a pad
    function automatic logic [26:0] uppg_pack(input logic [31:0] full);
        uppg_pack = {full[31:8], full[7:5]};
    endfunction

    // Open-drain ones release; push-pull ones always drive
    assign oe_full = pins.mode_bits | ~pins.data_bits;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin_out <= 27'h7FFFFFF;
            pin_oe <= 27'h0;
            pin_pullup_en <= 1'b1;
        end
        else
        begin
            pin_out <= uppg_pack(pins.data_bits);
            pin_oe <= uppg_pack(oe_full);
            pin_pullup_en <= ~pins.pullup_dis;
        end
    end
endmodule

// File: uppg_upper_port_gpio.sv
// APB register file and pin logic for the upper general-purpose ports
//
// The implementer's own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`include "uppg_defines.svh"
// How it works
// - Normal data reads return the pin level
// - Read-modify-write reads the stored data register
// - Fourth port has only pins five to seven
// - Port registers respond only on page fifteen
// - Push-pull: zero drives low, one drives high
// - Open-drain: zero drives low, one floats
// - Mode bit one push-pull, zero open-drain
// - Reset leaves every pin open-drain
// - Pull-ups on unless global disable bit set
// - Absent pins have no data register bits and read zero
// - Port data reached as whole bytes only
module uppg_upper_port_gpio
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [26:0] pin_in,
    output logic [26:0] pin_out,
    output logic [26:0] pin_oe,
    output logic pin_pullup_en
);
    uppg_pin_if pins();

    logic [7:0] register_page_select_reg;
    logic global_pullup_disable_reg;
    logic [7:0] data_reg [4];
    logic [7:0] pin_output_mode_bits_reg [4];
    logic [7:0] rmw_src_reg;
    logic [7:0] rmw_last_reg;
    uppg_pkg::uppg_rmw_state_t rmw_state_reg;
    logic [26:0] pin_level;
    logic [31:0] level_full;

    logic access;
    logic port_page;
    logic is_data;
    logic is_mode;
    logic is_rmw;
    logic is_ctrl;
    logic port_hit;
    logic refuse;
    logic ready_next;
    logic commit;
    uppg_pkg::uppg_port_idx_t port_idx;
    uppg_pkg::uppg_port_idx_t rmw_port;
    uppg_pkg::uppg_rmw_op_t rmw_op;
    logic [7:0] rmw_arg;
    logic [31:0] rdata_next;
    logic wr_commit;
    logic data_wr;
    logic mode_wr;
    logic rmw_busy;
    logic [7:0] rmw_result;

    // Mask of pins that exist on a port
    function automatic logic [7:0] uppg_mask(input uppg_pkg::uppg_port_idx_t idx);
        uppg_mask = (idx == 2'd0) ? `UPPG_P4_MASK : `UPPG_FULL_MASK;
    endfunction

    // Port number from a register offset
    function automatic uppg_pkg::uppg_port_idx_t uppg_port_of(input logic [11:0] addr);
        uppg_port_of = addr[3:2];
    endfunction

    // Register bank match, shared by the data and mode decodes
    function automatic logic uppg_in_bank(input logic [11:0] addr, input logic [11:0] base);
        uppg_in_bank = ((addr & `UPPG_BANK_MASK) == base);
    endfunction

    // Modify step of a read-modify-write
    function automatic logic [7:0] uppg_modify(
        input uppg_pkg::uppg_rmw_op_t op,
        input logic [7:0] src,
        input logic [7:0] arg
    );
        unique case (op)
            uppg_pkg::UPPG_OP_AND: uppg_modify = src & arg;
            uppg_pkg::UPPG_OP_OR: uppg_modify = src | arg;
            uppg_pkg::UPPG_OP_XOR: uppg_modify = src ^ arg;
            uppg_pkg::UPPG_OP_CPL: uppg_modify = ~src;
        endcase
    endfunction

    // Input paths exist only for the bonded pads
    uppg_sync u_sync
    (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(pin_in),
        .sync_out(pin_level)
    );

    uppg_pad_drive u_pad
    (
        .pclk(pclk),
        .presetn(presetn),
        .pins(pins.pad),
        .pin_out(pin_out),
        .pin_oe(pin_oe),
        .pin_pullup_en(pin_pullup_en)
    );

    // Absent low pins of the fourth port read zero
    assign level_full = {pin_level[26:3], pin_level[2:0], 5'h00};

    assign pins.data_bits = {data_reg[3], data_reg[2], data_reg[1], data_reg[0]};
    assign pins.mode_bits = {pin_output_mode_bits_reg[3], pin_output_mode_bits_reg[2],
                             pin_output_mode_bits_reg[1], pin_output_mode_bits_reg[0]};
    assign pins.pullup_dis = global_pullup_disable_reg;

    assign access = psel & penable & ~pready;
    assign commit = psel & penable & pready;
    assign port_page = (register_page_select_reg == `UPPG_PORT_PAGE);
    assign is_data = uppg_in_bank(paddr, `UPPG_DATA_BASE);
    assign is_mode = uppg_in_bank(paddr, `UPPG_MODE_BASE);
    assign is_rmw = (paddr == `UPPG_RMW_OFS);
    assign is_ctrl = (paddr == `UPPG_PAGE_OFS) || (paddr == `UPPG_CFG_OFS)
                     || (paddr == `UPPG_STAT_OFS);
    assign port_hit = is_data || is_mode || (is_rmw && pwrite);
    assign refuse = ~(is_ctrl || port_hit) || (port_hit && !port_page)
                    || (paddr[1:0] != 2'b00);
    assign port_idx = uppg_port_of(paddr);
    assign rmw_port = pwdata[`UPPG_RMW_PORT_MSB:`UPPG_RMW_PORT_LSB];
    assign rmw_op = uppg_pkg::uppg_rmw_op_t'(pwdata[`UPPG_RMW_OP_MSB:`UPPG_RMW_OP_LSB]);
    assign rmw_arg = pwdata[`UPPG_RMW_ARG_MSB:`UPPG_RMW_ARG_LSB];

    // Page, config, data and mode writes land only at the edge that completes the transfer
    assign wr_commit = commit && pwrite && !pslverr;
    assign data_wr = wr_commit && is_data;
    assign mode_wr = wr_commit && is_mode;

    // Modified byte; absent port four pins stay clear
    assign rmw_result = uppg_modify(rmw_op, rmw_src_reg, rmw_arg) & uppg_mask(rmw_port);

    // A read-modify-write holds the bus until its write-back is done
    assign rmw_busy = is_rmw && pwrite && (rmw_state_reg != uppg_pkg::UPPG_ST_DONE);
    assign ready_next = access && (refuse || !rmw_busy);

    // Read mux
    always_comb
    begin
        rdata_next = 32'h0;
        if (!refuse)
        begin
            if (is_data)
            begin
                rdata_next = {24'h0, level_full[8*port_idx +: 8]};
            end
            else if (is_mode)
            begin
                rdata_next = {24'h0, pin_output_mode_bits_reg[port_idx]};
            end
            else if (paddr == `UPPG_PAGE_OFS)
            begin
                rdata_next = {24'h0, register_page_select_reg};
            end
            else if (paddr == `UPPG_CFG_OFS)
            begin
                rdata_next[`UPPG_CFG_PUD_BIT] = global_pullup_disable_reg;
            end
            else if (paddr == `UPPG_STAT_OFS)
            begin
                rdata_next[`UPPG_STAT_PAGE_BIT] = port_page;
                rdata_next[`UPPG_STAT_LAST_MSB:`UPPG_STAT_LAST_LSB] = rmw_last_reg;
            end
        end
    end

    // Bus answer: one wait state on plain accesses
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
        end
        else
        begin
            pready <= ready_next;
            if (ready_next)
            begin
                pslverr <= refuse;
                prdata <= pwrite ? 32'h0 : rdata_next;
            end
            else
            begin
                pslverr <= 1'b0;
            end
        end
    end

    // Page select and pull-up disable
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            register_page_select_reg <= `UPPG_PAGE_RST;
            global_pullup_disable_reg <= `UPPG_PUD_RST;
        end
        else if (wr_commit)
        begin
            if (paddr == `UPPG_PAGE_OFS)
            begin
                register_page_select_reg <= pwdata[7:0];
            end
            if (paddr == `UPPG_CFG_OFS)
            begin
                global_pullup_disable_reg <= pwdata[`UPPG_CFG_PUD_BIT];
            end
        end
    end

    // Output mode registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int i = 0; i < 4; i++)
            begin
                pin_output_mode_bits_reg[i] <= `UPPG_MODE_RST;
            end
        end
        else if (mode_wr)
        begin
            pin_output_mode_bits_reg[port_idx] <= pwdata[7:0] & uppg_mask(port_idx);
        end
    end

    // Read-modify-write sequencer: read phase sees the stored byte
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rmw_state_reg <= uppg_pkg::UPPG_ST_IDLE;
            rmw_src_reg <= 8'h00;
            rmw_last_reg <= 8'h00;
        end
        else
        begin
            unique case (rmw_state_reg)
                uppg_pkg::UPPG_ST_IDLE:
                begin
                    // Refused commands never start the sequencer
                    if (access && is_rmw && pwrite && !refuse)
                    begin
                        rmw_state_reg <= uppg_pkg::UPPG_ST_READ;
                    end
                end
                uppg_pkg::UPPG_ST_READ:
                begin
                    rmw_src_reg <= data_reg[rmw_port];
                    rmw_last_reg <= data_reg[rmw_port];
                    rmw_state_reg <= uppg_pkg::UPPG_ST_WRITE;
                end
                uppg_pkg::UPPG_ST_WRITE:
                begin
                    rmw_state_reg <= uppg_pkg::UPPG_ST_DONE;
                end
                uppg_pkg::UPPG_ST_DONE:
                begin
                    if (commit)
                    begin
                        rmw_state_reg <= uppg_pkg::UPPG_ST_IDLE;
                    end
                end
            endcase
        end
    end

    // Data registers: byte writes and read-modify-write results
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int i = 0; i < 4; i++)
            begin
                data_reg[i] <= `UPPG_DATA_RST & uppg_mask(uppg_pkg::uppg_port_idx_t'(i));
            end
        end
        else if (rmw_state_reg == uppg_pkg::UPPG_ST_WRITE)
        begin
            data_reg[rmw_port] <= rmw_result;
        end
        else if (data_wr)
        begin
            // Whole byte only; upper bus bits ignored
            data_reg[port_idx] <= pwdata[7:0] & uppg_mask(port_idx);
        end
    end

endmodule

// File: uppg_upper_port_gpio_checker.sv
// Assertion checker for the upper port block
`timescale 1ns/1ps
module uppg_upper_port_gpio_checker
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [26:0] pin_in,
    input wire logic [26:0] pin_out,
    input wire logic [26:0] pin_oe,
    input wire logic pin_pullup_en
);
    logic [7:0] page_reg;
    logic port_acc;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // Own copy of the page, so refusals are judged independently
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            page_reg <= 8'h00;
        else if (psel && penable && pready && pwrite && !pslverr && paddr == 12'h000)
            page_reg <= pwdata[7:0];
    assign port_acc = psel && pready && paddr[11:6] == 6'h00 && paddr[5:4] != 2'h0;
    property p_release;
        (~pin_oe & ~pin_out) == 27'h0;
    endproperty
    a_release: assert property (p_release) else $error("undriven pin low");
    property p_reset;
        $rose(presetn) |-> pin_oe == 27'h0 && pin_out == 27'h7FFFFFF && pin_pullup_en;
    endproperty
    a_reset: assert property (p_reset) else $error("pins wrong after reset");
    property p_one;
        pready |=> !pready;
    endproperty
    a_one: assert property (p_one) else $error("ready longer than one cycle");
    property p_err;
        pslverr |-> pready;
    endproperty
    a_err: assert property (p_err) else $error("error without ready");
    property p_page;
        port_acc && page_reg != 8'h0F |-> pslverr;
    endproperty
    a_page: assert property (p_page) else $error("port access off page");
    property p_p4;
        psel && pready && !pwrite && paddr == 12'h010 |-> prdata[4:0] == 5'h00
            && prdata[31:8] == 24'h0;
    endproperty
    a_p4: assert property (p_p4) else $error("missing port bits set");
    property p_stat;
        psel && pready && !pwrite && paddr == 12'h00C |-> prdata[0] == (page_reg == 8'h0F);
    endproperty
    a_stat: assert property (p_stat) else $error("page status wrong");
    property p_cause;
        $changed(pin_out) || $changed(pin_oe) |-> $past(pready, 2)
            || (pready && $past(penable) && $past(pwrite) && $past(paddr) == 12'h008);
    endproperty
    a_cause: assert property (p_cause) else $error("pin moved without write");
endmodule

bind uppg_upper_port_gpio uppg_upper_port_gpio_checker i_chk (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .pin_in, .pin_out,
    .pin_oe, .pin_pullup_en);

// File: uppg_pin_model.sv
// External circuitry on the port pins
`timescale 1ns/1ps
module uppg_pin_model
(
    input wire logic pclk,
    input wire logic [26:0] pin_out,
    input wire logic [26:0] pin_oe,
    input wire logic pin_pullup_en,
    input wire logic [26:0] ext_en,
    input wire logic [26:0] ext_val,
    output logic [26:0] pin_in
);
    // Floating pins wander, so a stale level never passes
    logic [26:0] noise = 27'h5A5A5A5;
    always @(posedge pclk)
        noise <= ~noise;
    always_comb
        for (int i = 0; i < 27; i++)
            pin_in[i] = pin_oe[i] ? pin_out[i] : ext_en[i] ? ext_val[i] :
                pin_pullup_en ? 1'h1 : noise[i];
endmodule

// File: uppg_upper_port_gpio_test.sv
// Self-checking testbench for the upper port block
`timescale 1ns/1ps
module uppg_upper_port_gpio_test;
    logic pclk = 1'h0;
    logic presetn, psel, penable, pwrite, pready, pslverr, pin_pullup_en, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r, dv, mv;
    logic [26:0] pin_in, pin_out, pin_oe, ext_en, ext_val;
    logic [7:0] d, m, a, old;
    logic [1:0] n;
    int errors = 0;
    int num_checks = 0;

    uppg_upper_port_gpio i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .pin_in, .pin_out, .pin_oe, .pin_pullup_en);
    uppg_pin_model i_pins (.pclk, .pin_out, .pin_oe, .pin_pullup_en, .ext_en, .ext_val,
        .pin_in);

    always #4 pclk = ~pclk;

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'h1;
        while (pready !== 1'h1)
            @(posedge pclk);
        r = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    function automatic logic [7:0] rmw(input logic [1:0] op, input logic [7:0] s, x);
        case (op)
            2'h0: return s & x;
            2'h1: return s | x;
            2'h2: return s ^ x;
            default: return ~s;
        endcase
    endfunction

    // Unpinned lower port four bits are dropped by the slice
    function automatic logic [26:0] level();
        logic [26:0] oe;
        oe = mv[31:5] | ~dv[31:5];
        return (oe & dv[31:5]) | (~oe & (ext_val | ~ext_en));
    endfunction

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial
    begin
        repeat (4000) @(posedge pclk);
        errors++;
        wrap_up();
    end

    initial
    begin
        void'($urandom(80));
        {presetn, psel, penable, pwrite} = 4'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        ext_en = 27'h0;
        ext_val = 27'h0;
        dv = 32'hFFFFFFE0;
        mv = 32'h0;
        repeat (3) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
        check(pin_oe, 32'h0);
        check(pin_out, 32'h7FFFFFF);
        check(pin_pullup_en, 32'h1);
        apb(1'h1, 12'h014, 32'h0);
        check(e, 32'h1);
        apb(1'h1, 12'h000, 32'h0F);
        apb(1'h0, 12'h00C, 32'h0);
        check(r[0], 32'h1);
        apb(1'h0, 12'h014, 32'h0);
        check(r, 32'hFF);
        apb(1'h0, 12'h010, 32'h0);
        check(r, 32'hE0);
        apb(1'h0, 12'h100, 32'h0);
        check(e, 32'h1);
        apb(1'h1, 12'h004, 32'h1);
        repeat (2) @(posedge pclk);
        check(pin_pullup_en, 32'h0);
        apb(1'h1, 12'h004, 32'h0);
        $display("test reset_and_control done");
        for (int k = 0; k < 16; k++)
        begin
            n = 2'($urandom_range(3));
            d = k == 0 ? 8'hFF : 8'($urandom);
            m = k == 0 ? 8'h00 : k == 1 ? 8'hFF : 8'($urandom);
            ext_en <= 27'($urandom);
            ext_val <= 27'($urandom);
            apb(1'h1, {6'h00, 2'h1, n, 2'h0}, {24'h0, d});
            apb(1'h1, {6'h00, 2'h2, n, 2'h0}, {24'h0, m});
            dv[8 * n +: 8] = d;
            mv[8 * n +: 8] = m;
            dv[4:0] = 5'h0;
            repeat (3) @(posedge pclk);
            check(pin_out, dv[31:5]);
            check(pin_oe, 27'(mv[31:5] | ~dv[31:5]));
            apb(1'h0, {6'h00, 2'h1, n, 2'h0}, 32'h0);
            check(r, {24'h0, 8'({level(), 5'h0} >> (8 * n))});
        end
        $display("test pin_modes done");
        for (int k = 0; k < 4; k++)
        begin
            n = 2'($urandom_range(3));
            a = k == 3 ? 8'hFF : 8'($urandom);
            old = 8'(dv >> (8 * n));
            apb(1'h1, {6'h00, 2'h2, n, 2'h0}, 32'h0);
            mv[8 * n +: 8] = 8'h00;
            ext_en <= 27'h7FFFFFF;
            ext_val <= ~dv[31:5];
            apb(1'h1, 12'h008, {16'h0, a, 4'h0, 2'(k), n});
            dv[8 * n +: 8] = rmw(2'(k), old, a);
            dv[4:0] = 5'h0;
            apb(1'h0, 12'h00C, 32'h0);
            check(r[15:8], old);
            repeat (2) @(posedge pclk);
            check(pin_out, dv[31:5]);
        end
        $display("test read_modify_write done");
        apb(1'h1, 12'h000, 32'h00);
        apb(1'h1, 12'h018, 32'h5A);
        check(e, 32'h1);
        apb(1'h1, 12'h011, 32'h0);
        check(e, 32'h1);
        repeat (2) @(posedge pclk);
        check(pin_out, dv[31:5]);
        apb(1'h0, 12'h00C, 32'h0);
        check(r[0], 32'h0);
        $display("test refusals done");
        wrap_up();
    end
endmodule
